// ### hdl/lane_cfg_pkg.sv
// constants of the lane conditioning configuration register bank
package lane_cfg_pkg;
  // register offsets
  localparam logic [7:0] A1_DEEMPH_STATUS_OFS = 8'h35;
  localparam logic [7:0] A1_IDLE_THRESHOLD_OFS = 8'h36;
  localparam logic [7:0] A2_QUIET_LOAD_SENSE_OFS = 8'h39;
  localparam logic [7:0] A2_BOOST_OFS = 8'h3A;
  localparam logic [7:0] A2_SWING_OFS = 8'h3B;
  localparam logic [7:0] A2_DEEMPH_STATUS_OFS = 8'h3C;
  localparam logic [7:0] A2_IDLE_THRESHOLD_OFS = 8'h3D;
  // values after reset
  localparam logic [7:0] DEEMPH_STATUS_RST = 8'h02;
  localparam logic [7:0] IDLE_THRESHOLD_RST = 8'h00;
  localparam logic [7:0] QUIET_LOAD_SENSE_RST = 8'h00;
  localparam logic [7:0] BOOST_RST = 8'h2F;
  localparam logic [7:0] SWING_RST = 8'hAD;
  // field positions
  localparam int PRESENCE_BIT = 7;
  localparam int RATE_STATE_HI = 6;
  localparam int RATE_STATE_LO = 5;
  localparam int DEEMPH_RSV_HI = 4;
  localparam int DEEMPH_LEVEL_HI = 2;
  localparam int RELEASE_THR_HI = 3;
  localparam int RELEASE_THR_LO = 2;
  localparam int ENTRY_THR_HI = 1;
  localparam int AUTO_QUIET_BIT = 5;
  localparam int QUIET_FORCE_BIT = 4;
  localparam int LOAD_MODE_HI = 3;
  localparam int LOAD_MODE_LO = 2;
  localparam int SHORT_PROT_BIT = 7;
  localparam int RATE_SEL_BIT = 6;
  localparam int SWING_LEVEL_HI = 2;
  // writable mask of the mixed de-emphasis and status registers
  localparam logic [7:0] DEEMPH_WR_MASK = 8'h1F;
  // load sense mode codes
  typedef enum logic [1:0] {
    LOAD_HIGH_Z = 2'h0,
    LOAD_DETECT_LIMITED = 2'h1,
    LOAD_DETECT_ENDLESS = 2'h2,
    LOAD_FIXED_50 = 2'h3
  } load_mode_t;
  // rate detect state codes
  localparam logic [1:0] RATE_FIRST_GEN = 2'h0;
  localparam logic [1:0] RATE_SECOND_GEN = 2'h1;
  localparam logic [1:0] RATE_THIRD_GEN = 2'h3;
  // receiver test timing
  localparam int unsigned CLK_FREQ_KHZ = 200000;
  localparam int unsigned RETRY_PERIOD_MS = 12;
  localparam int unsigned RETRY_WINDOW_MS = 600;
  localparam int unsigned RETRY_PERIOD_CYCLES = RETRY_PERIOD_MS * CLK_FREQ_KHZ;
  localparam int unsigned ATTEMPT_LIMIT = RETRY_WINDOW_MS / RETRY_PERIOD_MS;
  localparam int PERIOD_CNT_W = 22;
  localparam int ATTEMPT_W = 6;
endpackage : lane_cfg_pkg

// ### hdl/load_sense_seq.sv
// receiver presence test sequencer for one output
`timescale 1ns/1ps
module load_sense_seq
  import lane_cfg_pkg::*;
#(
  parameter int unsigned RETRY_CYC = RETRY_PERIOD_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire lane_cfg_pkg::load_mode_t mode,
  input wire logic rx_sense,
  output logic test_strobe,
  output logic detected,
  output logic term_50
);
  import lane_cfg_pkg::*;

  typedef enum logic [1:0] {SEQ_OFF, SEQ_WAIT, SEQ_FOUND, SEQ_GIVEUP} seq_state_t;

  seq_state_t state_q;
  seq_state_t state_d;
  load_mode_t mode_q;
  logic [PERIOD_CNT_W-1:0] cnt_q;
  logic [ATTEMPT_W-1:0] tries_q;
  logic restart;
  logic detecting;
  logic last_try;

  // a new mode restarts the whole test schedule
  assign restart = (mode != mode_q);
  assign detecting = (mode == LOAD_DETECT_LIMITED) || (mode == LOAD_DETECT_ENDLESS);
  assign test_strobe = (state_q == SEQ_WAIT) && !restart && (cnt_q == '0);
  assign last_try = (mode == LOAD_DETECT_LIMITED) &&
                    (tries_q == ATTEMPT_W'(ATTEMPT_LIMIT - 1)); // R12

  // next state of the schedule
  always_comb begin
    state_d = state_q;
    if (restart) begin
      state_d = detecting ? SEQ_WAIT : SEQ_OFF;
    end else if (test_strobe) begin
      if (rx_sense) begin
        state_d = SEQ_FOUND; // R13
      end else if (last_try) begin
        state_d = SEQ_GIVEUP; // R12
      end
    end
  end

  // first test right on entry, then once a period
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= SEQ_OFF;
      mode_q <= LOAD_HIGH_Z;
      cnt_q <= '0;
      tries_q <= '0;
    end else begin
      state_q <= state_d;
      mode_q <= mode;
      if (restart) begin
        cnt_q <= '0;
        tries_q <= '0;
      end else if (test_strobe) begin
        cnt_q <= PERIOD_CNT_W'(RETRY_CYC - 1);
        tries_q <= tries_q + ATTEMPT_W'(1);
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - PERIOD_CNT_W'(1);
      end
    end
  end

  // outside fixed 50 ohm mode, termination stays high impedance until a receiver is found
  assign detected = (state_q == SEQ_FOUND) && !restart;
  assign term_50 = (mode == LOAD_FIXED_50) || detected; // R11 R12 R13

  // helper: cycles since the previous test
  logic [PERIOD_CNT_W-1:0] gap_q;
  logic seen_q;
  always_ff @(posedge clk) begin
    if (reset || restart) begin
      gap_q <= '0;
      seen_q <= 1'b0;
    end else if (test_strobe) begin
      gap_q <= '0;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + PERIOD_CNT_W'(1);
    end
  end

  test_spacing_a: assert property ( // R12
    @(posedge clk) disable iff (reset)
    test_strobe && seen_q |-> gap_q == PERIOD_CNT_W'(RETRY_CYC - 1))
    else $error("receiver tests not one period apart");
  attempt_limit_a: assert property ( // R12
    @(posedge clk) disable iff (reset)
    mode == LOAD_DETECT_LIMITED && !restart |-> tries_q <= ATTEMPT_W'(ATTEMPT_LIMIT))
    else $error("limited detection exceeded its attempts");
  endless_retry_a: assert property ( // R13
    @(posedge clk) disable iff (reset)
    mode == LOAD_DETECT_ENDLESS && state_q == SEQ_GIVEUP |-> restart)
    else $error("endless detection gave up");
  found_term_a: assert property ( // R13
    @(posedge clk) disable iff (reset)
    test_strobe && rx_sense ##1 !restart |-> term_50 && detected)
    else $error("detection did not switch termination");
  found_c: cover property (@(posedge clk) disable iff (reset) test_strobe && rx_sense);
  giveup_c: cover property (@(posedge clk) disable iff (reset) test_strobe && last_try);
endmodule : load_sense_seq

// ### hdl/lane_conditioning_config_regs.sv
// configuration and observation registers of channels a1 and a2
`timescale 1ns/1ps
// Behaviour
// R1: bit 7 reads receiver detected; register resets 0x02
// R2: bits 6:5 report detected rate generation
// R3: bits 2:0 select de-emphasis, default 010
// R4: software keeps swing bits 5:3 at 101
// R5: bits 3:2 select idle release threshold
// R6: bits 1:0 select idle entry threshold
// R7: threshold register fields override threshold pin
// R8: auto quiet enable selects automatic idle detect
// R9: quiet force mutes output when automatic off
// R10: quiet bits override otherwise applied idle control
// R11: mode 00 high impedance, 11 fixed 50 ohm
// R12: mode 01 tests every 12 ms, 50 tries
// R13: mode 10 tests every 12 ms until found
// R14: load sense field overrides receiver detect strap
// R15: boost level is 8 bits, resets 0x2F
// R16: swing bit 7 controls short protection, default set
// R17: rate select bit overrides mode strap pin
// R18: swing level bits 2:0, default 101
// R19: software writes zero to other reserved bits
// R20: writes to status bits are ignored
module lane_conditioning_config_regs
  import lane_cfg_pkg::*;
#(
  parameter int unsigned RETRY_CYC = RETRY_PERIOD_CYCLES
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // register access port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WRITE,
  input wire logic REG_READ,
  output logic [7:0] REG_RDATA,
  // strap pins
  input wire logic [3:0] SIGNAL_THRESHOLD_PIN,
  input wire lane_cfg_pkg::load_mode_t LOAD_SENSE_PIN,
  input wire logic RATE_SELECT_PIN,
  input wire logic IDLE_CONTROL_PIN,
  // analog observation
  input wire logic A1_RX_PRESENT,
  input wire logic [1:0] A1_RATE_STATE,
  input wire logic A2_IDLE_SENSED,
  input wire logic A2_RX_SENSE,
  input wire logic [1:0] A2_RATE_STATE,
  // channel a1 controls
  output logic [2:0] A1_DEEMPH_LEVEL,
  output logic [1:0] A1_RELEASE_THR,
  output logic [1:0] A1_ENTRY_THR,
  // channel a2 controls
  output logic [7:0] A2_BOOST_LEVEL,
  output logic [2:0] A2_SWING_LEVEL,
  output logic A2_SHORT_PROTECT,
  output logic A2_RATE_SELECT,
  output logic [2:0] A2_DEEMPH_LEVEL,
  output logic [1:0] A2_RELEASE_THR,
  output logic [1:0] A2_ENTRY_THR,
  output logic A2_OUTPUT_MUTE,
  output logic A2_TERM_50,
  output logic A2_DETECT_PULSE
);
  import lane_cfg_pkg::*;

  // stored register bytes; status bits are not stored
  logic [7:0] a1_dem_q;
  logic [7:0] a1_thr_q;
  logic [7:0] a2_quiet_q;
  logic [7:0] a2_boost_q;
  logic [7:0] a2_swing_q;
  logic [7:0] a2_dem_q;
  logic [7:0] a2_thr_q;
  // set on first write; until then the straps steer
  logic a1_thr_ovr_q;
  logic a2_thr_ovr_q;
  logic a2_quiet_ovr_q;
  logic a2_rate_ovr_q;
  // straps caught while reset is held
  logic [3:0] strap_thr_q;
  load_mode_t strap_load_q;
  logic strap_rate_q;
  logic strap_idle_q;

  // address decode
  logic wr_a1_dem;
  logic wr_a1_thr;
  logic wr_a2_quiet;
  logic wr_a2_boost;
  logic wr_a2_swing;
  logic wr_a2_dem;
  logic wr_a2_thr;
  assign wr_a1_dem = REG_WRITE && (REG_ADDR == A1_DEEMPH_STATUS_OFS);
  assign wr_a1_thr = REG_WRITE && (REG_ADDR == A1_IDLE_THRESHOLD_OFS);
  assign wr_a2_quiet = REG_WRITE && (REG_ADDR == A2_QUIET_LOAD_SENSE_OFS);
  assign wr_a2_boost = REG_WRITE && (REG_ADDR == A2_BOOST_OFS);
  assign wr_a2_swing = REG_WRITE && (REG_ADDR == A2_SWING_OFS);
  assign wr_a2_dem = REG_WRITE && (REG_ADDR == A2_DEEMPH_STATUS_OFS);
  assign wr_a2_thr = REG_WRITE && (REG_ADDR == A2_IDLE_THRESHOLD_OFS);

  // sync reset; straps are sampled on every clock edge while reset is held
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      strap_thr_q <= SIGNAL_THRESHOLD_PIN;
      strap_load_q <= LOAD_SENSE_PIN;
      strap_rate_q <= RATE_SELECT_PIN;
      strap_idle_q <= IDLE_CONTROL_PIN;
    end
  end

  // register bytes; reserved bits are kept as written
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      a1_dem_q <= DEEMPH_STATUS_RST & DEEMPH_WR_MASK; // R1 R3
      a1_thr_q <= IDLE_THRESHOLD_RST; // R5 R6
      a2_quiet_q <= QUIET_LOAD_SENSE_RST;
      a2_boost_q <= BOOST_RST; // R15
      a2_swing_q <= SWING_RST; // R16 R18
      a2_dem_q <= DEEMPH_STATUS_RST & DEEMPH_WR_MASK;
      a2_thr_q <= IDLE_THRESHOLD_RST;
    end else begin
      if (wr_a1_dem) a1_dem_q <= REG_WDATA & DEEMPH_WR_MASK; // R20
      if (wr_a1_thr) a1_thr_q <= REG_WDATA;
      if (wr_a2_quiet) a2_quiet_q <= REG_WDATA;
      if (wr_a2_boost) a2_boost_q <= REG_WDATA; // R15
      if (wr_a2_swing) a2_swing_q <= REG_WDATA; // R4
      if (wr_a2_dem) a2_dem_q <= REG_WDATA & DEEMPH_WR_MASK; // R20
      if (wr_a2_thr) a2_thr_q <= REG_WDATA;
    end
  end

  // override flags; once software writes, the strap no longer counts
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      a1_thr_ovr_q <= 1'b0;
      a2_thr_ovr_q <= 1'b0;
      a2_quiet_ovr_q <= 1'b0;
      a2_rate_ovr_q <= 1'b0;
    end else begin
      a1_thr_ovr_q <= a1_thr_ovr_q | wr_a1_thr; // R7
      a2_thr_ovr_q <= a2_thr_ovr_q | wr_a2_thr; // R7
      a2_quiet_ovr_q <= a2_quiet_ovr_q | wr_a2_quiet; // R10 R14
      a2_rate_ovr_q <= a2_rate_ovr_q | wr_a2_swing; // R17
    end
  end

  // effective settings after the register-over-strap choice
  logic [1:0] a1_rel_eff;
  logic [1:0] a1_ent_eff;
  logic [1:0] a2_rel_eff;
  logic [1:0] a2_ent_eff;
  logic a2_rate_eff;
  load_mode_t load_mode_eff;
  logic auto_quiet;
  logic quiet_force;
  logic mute_eff;
  assign a1_rel_eff = a1_thr_ovr_q ? a1_thr_q[RELEASE_THR_HI:RELEASE_THR_LO]
                                   : strap_thr_q[RELEASE_THR_HI:RELEASE_THR_LO]; // R7 R5
  assign a1_ent_eff = a1_thr_ovr_q ? a1_thr_q[ENTRY_THR_HI:0]
                                   : strap_thr_q[ENTRY_THR_HI:0]; // R7 R6
  assign a2_rel_eff = a2_thr_ovr_q ? a2_thr_q[RELEASE_THR_HI:RELEASE_THR_LO]
                                   : strap_thr_q[RELEASE_THR_HI:RELEASE_THR_LO]; // R7 R5
  assign a2_ent_eff = a2_thr_ovr_q ? a2_thr_q[ENTRY_THR_HI:0]
                                   : strap_thr_q[ENTRY_THR_HI:0]; // R7 R6
  assign a2_rate_eff = a2_rate_ovr_q ? a2_swing_q[RATE_SEL_BIT] : strap_rate_q; // R17
  assign load_mode_eff = a2_quiet_ovr_q ? load_mode_t'(a2_quiet_q[LOAD_MODE_HI:LOAD_MODE_LO])
                                        : strap_load_q; // R14
  // idle pin high means automatic detect, low keeps the output on
  assign auto_quiet = a2_quiet_ovr_q ? a2_quiet_q[AUTO_QUIET_BIT] : strap_idle_q; // R10
  assign quiet_force = a2_quiet_ovr_q && a2_quiet_q[QUIET_FORCE_BIT]; // R10
  assign mute_eff = auto_quiet ? A2_IDLE_SENSED : quiet_force; // R8 R9

  // receiver presence test of the a2 output
  logic a2_detected;
  logic a2_term;
  logic a2_strobe;
  load_sense_seq #(
    .RETRY_CYC(RETRY_CYC)
  ) u_load_sense (
    .clk(SYS_CLK),
    .reset(RESET),
    .mode(load_mode_eff),
    .rx_sense(A2_RX_SENSE),
    .test_strobe(a2_strobe),
    .detected(a2_detected),
    .term_50(a2_term)
  );
  // the strobe is a handshake toward the analog test, so it is left combinational
  assign A2_DETECT_PULSE = a2_strobe; // R12 R13

  // read data composition; status bits are live observations
  logic [7:0] a1_dem_rd;
  logic [7:0] a2_dem_rd;
  logic [7:0] rd_mux;
  assign a1_dem_rd = {A1_RX_PRESENT, A1_RATE_STATE, a1_dem_q[DEEMPH_RSV_HI:0]}; // R1 R2
  assign a2_dem_rd = {a2_detected, A2_RATE_STATE, a2_dem_q[DEEMPH_RSV_HI:0]}; // R1 R2
  always_comb begin
    unique case (REG_ADDR)
      A1_DEEMPH_STATUS_OFS: rd_mux = a1_dem_rd;
      A1_IDLE_THRESHOLD_OFS: rd_mux = a1_thr_q;
      A2_QUIET_LOAD_SENSE_OFS: rd_mux = a2_quiet_q;
      A2_BOOST_OFS: rd_mux = a2_boost_q;
      A2_SWING_OFS: rd_mux = a2_swing_q;
      A2_DEEMPH_STATUS_OFS: rd_mux = a2_dem_rd;
      A2_IDLE_THRESHOLD_OFS: rd_mux = a2_thr_q;
      default: rd_mux = 8'h00; // unmapped addresses read zero
    endcase
  end

  // read data holds until the next read
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      REG_RDATA <= 8'h00;
    end else if (REG_READ) begin
      REG_RDATA <= rd_mux;
    end
  end

  // control outputs; one flop stage keeps the analog side glitch free
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      A1_DEEMPH_LEVEL <= DEEMPH_STATUS_RST[DEEMPH_LEVEL_HI:0];
      A1_RELEASE_THR <= 2'h0;
      A1_ENTRY_THR <= 2'h0;
      A2_BOOST_LEVEL <= BOOST_RST;
      A2_SWING_LEVEL <= SWING_RST[SWING_LEVEL_HI:0];
      A2_SHORT_PROTECT <= SWING_RST[SHORT_PROT_BIT];
      A2_RATE_SELECT <= SWING_RST[RATE_SEL_BIT];
      A2_DEEMPH_LEVEL <= DEEMPH_STATUS_RST[DEEMPH_LEVEL_HI:0];
      A2_RELEASE_THR <= 2'h0;
      A2_ENTRY_THR <= 2'h0;
      A2_OUTPUT_MUTE <= 1'b0;
      A2_TERM_50 <= 1'b0;
    end else begin
      A1_DEEMPH_LEVEL <= a1_dem_q[DEEMPH_LEVEL_HI:0]; // R3
      A1_RELEASE_THR <= a1_rel_eff;
      A1_ENTRY_THR <= a1_ent_eff;
      A2_BOOST_LEVEL <= a2_boost_q; // R15
      A2_SWING_LEVEL <= a2_swing_q[SWING_LEVEL_HI:0]; // R18
      A2_SHORT_PROTECT <= a2_swing_q[SHORT_PROT_BIT]; // R16
      A2_RATE_SELECT <= a2_rate_eff;
      A2_DEEMPH_LEVEL <= a2_dem_q[DEEMPH_LEVEL_HI:0]; // R3
      A2_RELEASE_THR <= a2_rel_eff;
      A2_ENTRY_THR <= a2_ent_eff;
      A2_OUTPUT_MUTE <= mute_eff;
      A2_TERM_50 <= a2_term; // R11
    end
  end

  // checks
  status_write_a: assert property ( // R20
    @(posedge SYS_CLK) disable iff (RESET)
    REG_WRITE && REG_ADDR == A2_DEEMPH_STATUS_OFS ##1 REG_READ &&
    REG_ADDR == A2_DEEMPH_STATUS_OFS |=> REG_RDATA[DEEMPH_RSV_HI:0] ==
    $past(REG_WDATA[DEEMPH_RSV_HI:0], 2) && REG_RDATA[PRESENCE_BIT] == $past(a2_detected))
    else $error("status bits took written data");
  rate_readback_a: assert property ( // R2
    @(posedge SYS_CLK) disable iff (RESET)
    REG_READ && REG_ADDR == A1_DEEMPH_STATUS_OFS |=>
    REG_RDATA[RATE_STATE_HI:RATE_STATE_LO] == $past(A1_RATE_STATE))
    else $error("rate state not reported");
  deemph_reset_a: assert property ( // R1 R3
    @(posedge SYS_CLK)
    RESET ##1 !RESET && REG_READ && REG_ADDR == A1_DEEMPH_STATUS_OFS && !A1_RX_PRESENT &&
    A1_RATE_STATE == 2'h0 |=> REG_RDATA == DEEMPH_STATUS_RST)
    else $error("de-emphasis register reset value wrong");
  boost_reset_a: assert property ( // R15 R16 R18
    @(posedge SYS_CLK)
    RESET |=> A2_BOOST_LEVEL == BOOST_RST && A2_SWING_LEVEL == SWING_RST[SWING_LEVEL_HI:0] &&
    A2_SHORT_PROTECT)
    else $error("boost or swing reset value wrong");
  threshold_ovr_a: assert property ( // R7
    @(posedge SYS_CLK) disable iff (RESET)
    wr_a2_thr ##1 !wr_a2_thr |=> A2_RELEASE_THR == $past(REG_WDATA[RELEASE_THR_HI:2], 2) &&
    A2_ENTRY_THR == $past(REG_WDATA[ENTRY_THR_HI:0], 2))
    else $error("threshold write did not override pin");
  force_mute_a: assert property ( // R9 R10
    @(posedge SYS_CLK) disable iff (RESET)
    a2_quiet_ovr_q && !a2_quiet_q[AUTO_QUIET_BIT] |=>
    A2_OUTPUT_MUTE == $past(a2_quiet_q[QUIET_FORCE_BIT]))
    else $error("quiet force not applied");
  auto_mute_a: assert property ( // R8
    @(posedge SYS_CLK) disable iff (RESET)
    a2_quiet_ovr_q && a2_quiet_q[AUTO_QUIET_BIT] |=> A2_OUTPUT_MUTE == $past(A2_IDLE_SENSED))
    else $error("automatic idle not followed");
  load_mode_ovr_a: assert property ( // R11 R14
    @(posedge SYS_CLK) disable iff (RESET)
    a2_quiet_ovr_q && a2_quiet_q[LOAD_MODE_HI:LOAD_MODE_LO] == 2'h0 |=> !A2_TERM_50)
    else $error("high impedance mode terminated");
  rate_ovr_a: assert property ( // R17
    @(posedge SYS_CLK) disable iff (RESET)
    wr_a2_swing |=> ##1 A2_RATE_SELECT == $past(REG_WDATA[RATE_SEL_BIT], 2))
    else $error("rate select did not override strap");
  quiet_write_c: cover property (@(posedge SYS_CLK) disable iff (RESET) wr_a2_quiet);
  muted_c: cover property (@(posedge SYS_CLK) disable iff (RESET) A2_OUTPUT_MUTE);
  detect_c: cover property (@(posedge SYS_CLK) disable iff (RESET) $rose(a2_detected));
endmodule : lane_conditioning_config_regs

// ### test/tb_lane_conditioning_config_regs.sv
// self-checking bench for the lane conditioning configuration registers
`timescale 1ns/1ps
module tb_lane_conditioning_config_regs;
  import lane_cfg_pkg::*;
  // short retry period keeps the receiver test sequences brief
  localparam int RC = 8;
  logic sys_clk, reset, reg_write, reg_read, rate_select_pin, idle_control_pin;
  logic a1_rx_present, a2_idle_sensed, a2_rx_sense, a2_short_protect, a2_rate_select;
  logic a2_output_mute, a2_term_50, a2_detect_pulse;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, a2_boost_level;
  logic [3:0] signal_threshold_pin;
  load_mode_t load_sense_pin;
  logic [1:0] a1_rate_state, a2_rate_state, a1_release_thr, a1_entry_thr;
  logic [1:0] a2_release_thr, a2_entry_thr;
  logic [2:0] a1_deemph_level, a2_swing_level, a2_deemph_level;
  int err_count = 0;
  int samples_checked = 0;
  int pulse_cnt = 0;
  lane_conditioning_config_regs #(.RETRY_CYC(RC)) u_dut (
    .SYS_CLK(sys_clk), .RESET(reset), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WRITE(reg_write), .REG_READ(reg_read), .REG_RDATA(reg_rdata),
    .SIGNAL_THRESHOLD_PIN(signal_threshold_pin), .LOAD_SENSE_PIN(load_sense_pin),
    .RATE_SELECT_PIN(rate_select_pin), .IDLE_CONTROL_PIN(idle_control_pin),
    .A1_RX_PRESENT(a1_rx_present), .A1_RATE_STATE(a1_rate_state),
    .A2_IDLE_SENSED(a2_idle_sensed), .A2_RX_SENSE(a2_rx_sense),
    .A2_RATE_STATE(a2_rate_state), .A1_DEEMPH_LEVEL(a1_deemph_level),
    .A1_RELEASE_THR(a1_release_thr), .A1_ENTRY_THR(a1_entry_thr),
    .A2_BOOST_LEVEL(a2_boost_level), .A2_SWING_LEVEL(a2_swing_level),
    .A2_SHORT_PROTECT(a2_short_protect), .A2_RATE_SELECT(a2_rate_select),
    .A2_DEEMPH_LEVEL(a2_deemph_level), .A2_RELEASE_THR(a2_release_thr),
    .A2_ENTRY_THR(a2_entry_thr), .A2_OUTPUT_MUTE(a2_output_mute),
    .A2_TERM_50(a2_term_50), .A2_DETECT_PULSE(a2_detect_pulse)
  );
  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // pulse tally, sampled mid-cycle where the combinational pulse is settled
  always @(negedge sys_clk) begin
    if (a2_detect_pulse === 1'b1) pulse_cnt++;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic end_of_test();
    if (err_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  // one write, then one more cycle so the output flops have caught up
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge sys_clk);
    reg_write = 1'b0;
    @(negedge sys_clk);
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge sys_clk);
    reg_read = 1'b0;
    d = reg_rdata;
  endtask : reg_rd
  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    reg_rd(a, d);
    check(d, exp);
  endtask : rd_check
  // waits n cycles and checks the spacing of every pulse pair seen
  task automatic watch(input int n);
    int last;
    last = -1;
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      if (a2_detect_pulse === 1'b1) begin
        if (last >= 0) check(8'(i - last), 8'(RC));
        last = i;
      end
    end
  endtask : watch
  task automatic test_reset_values();
    logic [7:0] addrs [7] = '{8'h35, 8'h36, 8'h39, 8'h3A, 8'h3B, 8'h3C, 8'h3D};
    logic [7:0] exps [7] = '{8'h02, 8'h00, 8'h00, 8'h2F, 8'hAD, 8'h02, 8'h00};
    for (int i = 0; i < 7; i++) rd_check(addrs[i], exps[i]);
    check(a2_boost_level, 8'h2F);
    check({a2_short_protect, 4'h0, a2_swing_level}, 8'h85);
    check({1'b0, a1_deemph_level, 1'b0, a2_deemph_level}, 8'h22);
    check(8'(a2_rate_select), 8'h01);
    check({a1_release_thr, a1_entry_thr, a2_release_thr, a2_entry_thr}, 8'hEE);
    check(8'(pulse_cnt != 0), 8'h01);
    reg_wr(8'h50, 8'h11);
    rd_check(8'h50, 8'h00);
    rd_check(8'h3A, 8'h2F);
  endtask : test_reset_values
  task automatic test_status_deemph();
    logic [1:0] rates [3] = '{2'h0, 2'h1, 2'h3};
    for (int c = 0; c < 8; c++) begin
      a2_rate_state = rates[c % 3];
      reg_wr(8'h3C, {3'b111, 2'b00, 3'(c)});
      check(8'(a2_deemph_level), 8'(c));
      rd_check(8'h3C, {1'b0, rates[c % 3], 2'b00, 3'(c)});
    end
    a1_rx_present = 1'b1;
    a1_rate_state = 2'h1;
    reg_wr(8'h35, 8'h07);
    check(8'(a1_deemph_level), 8'h07);
    rd_check(8'h35, 8'hA7);
    // write then read in the very next cycle; status bits written as ones
    @(negedge sys_clk);
    reg_addr = 8'h3C;
    reg_wdata = 8'hE7;
    reg_write = 1'b1;
    @(negedge sys_clk);
    reg_write = 1'b0;
    reg_read = 1'b1;
    @(negedge sys_clk);
    reg_read = 1'b0;
    check(reg_rdata, 8'h27);
  endtask : test_status_deemph
  task automatic test_boost_swing();
    reg_wr(8'h3A, 8'hFF);
    check(a2_boost_level, 8'hFF);
    reg_wr(8'h3A, 8'h00);
    check(a2_boost_level, 8'h00);
    for (int c = 0; c < 8; c++) begin
      reg_wr(8'h3B, 8'h28 | 8'(c) | (8'(c & 1) << 7) | (8'(c & 2) << 5));
      check({a2_short_protect, a2_rate_select, 3'h0, a2_swing_level},
            8'(c) | (8'(c & 1) << 7) | (8'(c & 2) << 5));
    end
  endtask : test_boost_swing
  task automatic test_thresholds();
    for (int c = 0; c < 4; c++) begin
      reg_wr(8'h3D, {4'h0, 2'(c), 2'(3 - c)});
      check({a2_release_thr, a2_entry_thr}, 8'({2'(c), 2'(3 - c)}));
    end
    reg_wr(8'h36, 8'h09);
    check({a1_release_thr, a1_entry_thr}, 8'h09);
  endtask : test_thresholds
  task automatic test_quiet();
    a2_idle_sensed = 1'b1;
    repeat (3) @(negedge sys_clk);
    check(8'(a2_output_mute), 8'h01);
    a2_idle_sensed = 1'b0;
    reg_wr(8'h39, 8'h10);
    check(8'(a2_output_mute), 8'h01);
    a2_idle_sensed = 1'b1;
    reg_wr(8'h39, 8'h00);
    check(8'(a2_output_mute), 8'h00);
    reg_wr(8'h39, 8'h20);
    check(8'(a2_output_mute), 8'h01);
    a2_idle_sensed = 1'b0;
    repeat (3) @(negedge sys_clk);
    check(8'(a2_output_mute), 8'h00);
    reg_wr(8'h39, 8'h00);
  endtask : test_quiet
  task automatic test_load_sense();
    int p0;
    int i;
    a2_rx_sense = 1'b0;
    p0 = pulse_cnt;
    reg_wr(8'h39, 8'h04);
    watch(60 * RC);
    check(8'(pulse_cnt - p0), 8'd50);
    check(8'(a2_term_50), 8'h00);
    p0 = pulse_cnt;
    reg_wr(8'h39, 8'h08);
    watch(60 * RC - 6);
    check(8'(pulse_cnt - p0), 8'd60);
    check(8'(a2_term_50), 8'h00);
    a2_rx_sense = 1'b1;
    for (i = 0; i < 4 * RC && a2_term_50 !== 1'b1; i++) @(negedge sys_clk);
    if (a2_term_50 !== 1'b1) begin
      check(8'(a2_term_50), 8'h01);
      end_of_test();
    end
    a2_rx_sense = 1'b0;
    rd_check(8'h3C, 8'hA7);
    p0 = pulse_cnt;
    watch(5 * RC);
    check(8'(pulse_cnt - p0), 8'h00);
    reg_wr(8'h39, 8'h0C);
    watch(5 * RC);
    check({3'h0, a2_term_50, 4'(pulse_cnt - p0)}, 8'h10);
    rd_check(8'h3C, 8'h27);
    reg_wr(8'h39, 8'h00);
    watch(5 * RC);
    check({3'h0, a2_term_50, 4'(pulse_cnt - p0)}, 8'h00);
  endtask : test_load_sense
  // main sequence
  initial begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    signal_threshold_pin = 4'hE;
    load_sense_pin = LOAD_DETECT_ENDLESS;
    rate_select_pin = 1'b1;
    idle_control_pin = 1'b1;
    a1_rx_present = 1'b0;
    a1_rate_state = 2'h0;
    a2_idle_sensed = 1'b0;
    a2_rx_sense = 1'b0;
    a2_rate_state = 2'h0;
    repeat (16) @(negedge sys_clk);
    reset = 1'b0;
    test_reset_values();
    test_status_deemph();
    test_boost_swing();
    test_thresholds();
    test_quiet();
    test_load_sense();
    end_of_test();
  end
endmodule : tb_lane_conditioning_config_regs
